//--- hw/lane_sync.sv
`timescale 1ns/1ps
`default_nettype none
module lane_sync
  import sram_host_pkg::*;
#(
  parameter int W = 8
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Lane to be retimed
  lane_sync_if.dst lane
);

  logic [W-1:0] stage1_ff;
  logic [W-1:0] stage2_ff;

  // Two flops; only the second stage is read, by the host's read data capture.
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end
    else
    begin
      stage1_ff <= lane.raw;
      stage2_ff <= stage1_ff;
    end
  end

  assign lane.synced = stage2_ff;

endmodule : lane_sync
`default_nettype wire

//--- hw/lane_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries the raw byte lane into the synchroniser and the retimed copy back.
interface lane_sync_if #(parameter int W = 8);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport src (output raw, input synced);
  modport dst (input raw, output synced);
endinterface : lane_sync_if
`default_nettype wire

//--- hw/sram_host.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - The host starts a write only by driving both chip select and write enable low.
// - The host times data setup and hold against the strobe that ends the write.
// - A write-enable write with output enable low lasts at least the float delay plus data setup.
// - The host waits at least 100 us after power is stable before its first access.
// - The host holds write enable high through every read.
// - In a read the address is valid no later than the falling edge of chip select.
// - The host does not drive write data while the memory may still drive the lane.
module sram_host
  import sram_host_pkg::*;
#(
  parameter int POWERUP_CYCLES = POWERUP_WAIT_CYCLES
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // User request port
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  // Memory pins
  output logic [ADDR_W-1:0] word_address,
  output logic chip_select_n,
  output logic output_enable_n,
  output logic write_enable_n,
  input wire logic [DATA_W-1:0] byte_lane_in,
  output logic [DATA_W-1:0] byte_lane_out,
  output logic byte_lane_oe
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  seq_state_t state_ff;
  logic [16:0] pwr_cnt_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] wdata_ff;
  logic cs_n_ff;
  logic oe_n_ff;
  logic we_n_ff;
  logic lane_oe_ff;
  logic rsp_valid_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic cnt_done;

  lane_sync_if #(.W(DATA_W)) lane_bus ();

  // ------------------------------------------------------------
  // Read-data synchroniser
  // ------------------------------------------------------------
  assign lane_bus.raw = byte_lane_in;

  lane_sync #(.W(DATA_W)) u_lane_sync
  (
    .mclk(mclk),
    .reset(reset),
    .lane(lane_bus.dst)
  );

  assign cnt_done = (cnt_ff == '0);

  // Power-up wait: no access until the counter has run out.
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      pwr_cnt_ff <= '0;
    else if (state_ff == ST_POWERUP)
      pwr_cnt_ff <= pwr_cnt_ff + 17'h00001;
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  // One access at a time; the dwell of ST_RD, ST_WR and ST_GAP is counted down in cnt_ff.
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      state_ff <= ST_POWERUP;
      cnt_ff <= '0;
    end
    else
    begin
      unique case (state_ff)
        ST_POWERUP:
        begin
          if (pwr_cnt_ff >= 17'(POWERUP_CYCLES - 1))
            state_ff <= ST_IDLE;
        end
        ST_IDLE:
        begin
          if (req_valid && req_write)
          begin
            state_ff <= ST_WR_SET;
            cnt_ff <= '0;
          end
          else if (req_valid)
          begin
            state_ff <= ST_RD;
            // Two extra cycles cover both synchroniser stages, so the byte is captured well after it settles.
            cnt_ff <= CNT_W'(READ_CYCLES + 2);
          end
        end
        ST_RD:
        begin
          if (cnt_done)
            state_ff <= ST_RD_CAP;
          else
            cnt_ff <= cnt_ff - 4'h1;
        end
        ST_RD_CAP:
        begin
          state_ff <= ST_GAP;
          cnt_ff <= CNT_W'(STANDBY_CYCLES - 1);
        end
        ST_WR_SET:
        begin
          state_ff <= ST_WR;
          // Longer of pulse width and float-plus-setup, so either case is met.
          cnt_ff <= CNT_W'((WRITE_LOW_CYCLES > WRITE_PULSE_CYCLES ? WRITE_LOW_CYCLES : WRITE_PULSE_CYCLES) - 1);
        end
        ST_WR:
        begin
          if (cnt_done)
            state_ff <= ST_WR_END;
          else
            cnt_ff <= cnt_ff - 4'h1;
        end
        ST_WR_END:
        begin
          state_ff <= ST_GAP;
          cnt_ff <= CNT_W'(STANDBY_CYCLES - 1);
        end
        ST_GAP:
        begin
          if (cnt_done)
            state_ff <= ST_IDLE;
          else
            cnt_ff <= cnt_ff - 4'h1;
        end
      endcase
    end
  end

  // Request capture; address and data are frozen for the whole access.
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      addr_ff <= '0;
      wdata_ff <= '0;
    end
    else if (state_ff == ST_IDLE && req_valid)
    begin
      addr_ff <= req_addr;
      wdata_ff <= req_wdata;
    end
  end

  // ------------------------------------------------------------
  // Pin strobes
  // ------------------------------------------------------------
  // Address is set one cycle before select falls, and held at least two cycles after the strobes rise.
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      cs_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      lane_oe_ff <= 1'b0;
    end
    else
    begin
      // Select low during read dwell and during write set-up and strobe.
      cs_n_ff <= !(state_ff == ST_RD || state_ff == ST_WR_SET || state_ff == ST_WR);
      // Output enable only for reads, so writes keep the memory off the lane.
      oe_n_ff <= !(state_ff == ST_RD);
      // Write enable stays high outside the write strobe, so reads never see it low.
      we_n_ff <= !(state_ff == ST_WR_SET || state_ff == ST_WR);
      // Data driven from the write strobe until one cycle after it rises, giving hold.
      lane_oe_ff <= (state_ff == ST_WR_SET || state_ff == ST_WR || state_ff == ST_WR_END);
    end
  end

  // Read data capture after the synchroniser has settled.
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      rdata_ff <= '0;
      rsp_valid_ff <= 1'b0;
    end
    else
    begin
      rsp_valid_ff <= (state_ff == ST_RD_CAP);
      if (state_ff == ST_RD_CAP)
        rdata_ff <= lane_bus.synced;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Both strobes rise on the same edge, ending the write while the host still drives the lane.
  assign chip_select_n = cs_n_ff;
  assign write_enable_n = we_n_ff;
  assign output_enable_n = oe_n_ff;
  assign word_address = addr_ff;
  assign byte_lane_out = wdata_ff;
  assign byte_lane_oe = lane_oe_ff;
  assign req_ready = (state_ff == ST_IDLE);
  assign rsp_valid = rsp_valid_ff;
  assign rsp_rdata = rdata_ff;

endmodule : sram_host
`default_nettype wire

//--- hw/sram_host_pkg.sv
package sram_host_pkg;

  // ------------------------------------------------------------
  // Geometry of the memory outside
  // ------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;

  // ------------------------------------------------------------
  // Timing, in ns or us as printed, and derived cycle counts
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int POWERUP_WAIT_TIME_US = 100;
  localparam int POWERUP_WAIT_CYCLES = (POWERUP_WAIT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYCLE_TIME_NS = 10;
  localparam int ACCESS_TIME_NS = 10;
  localparam int WRITE_PULSE_TIME_NS = 7;
  localparam int WRITE_STROBE_TO_FLOAT_TIME_NS = 5;
  localparam int WRITE_DATA_SETUP_TIME_NS = 5;
  localparam int DESELECT_TO_STANDBY_TIME_NS = 10;
  // Cycles of access time; the sequencer adds two more for the lane synchroniser.
  localparam int READ_CYCLES = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Write strobe long enough for the lane to float plus data setup, and the pulse width.
  localparam int WRITE_FLOAT_CYCLES = (WRITE_STROBE_TO_FLOAT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_SETUP_CYCLES = (WRITE_DATA_SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_PULSE_CYCLES = (WRITE_PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_LOW_CYCLES = WRITE_FLOAT_CYCLES + WRITE_SETUP_CYCLES;
  localparam int STANDBY_CYCLES = (DESELECT_TO_STANDBY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;

  // ------------------------------------------------------------
  // Sequencer states, Gray coded in the order listed
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POWERUP = 3'b000,
    ST_IDLE    = 3'b001,
    ST_RD      = 3'b011,
    ST_RD_CAP  = 3'b010,
    ST_WR_SET  = 3'b110,
    ST_WR      = 3'b111,
    ST_WR_END  = 3'b101,
    ST_GAP     = 3'b100
  } seq_state_t;

endpackage : sram_host_pkg

//--- tb/sram_host_props.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// Pin protocol checks on the host side
// ------------------------------------------------
module sram_host_props
  import sram_host_pkg::*;
#(
  parameter int POWERUP_CYCLES = 8
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // User side
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_ready,
  input wire logic rsp_valid,
  // Memory pins
  input wire logic [ADDR_W-1:0] word_address,
  input wire logic chip_select_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic [DATA_W-1:0] byte_lane_out,
  input wire logic byte_lane_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  logic [15:0] up_ff;
  // Counts cycles since reset; it saturates so a long run cannot wrap it.
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      up_ff <= 16'h0000;
    else if (up_ff < 16'(POWERUP_CYCLES))
      up_ff <= up_ff + 16'h0001;
  end
  a_powerup_quiet: assert property ((up_ff < 16'(POWERUP_CYCLES)) |-> chip_select_n)
    else $error("memory selected during power-up wait");
  a_start_both: assert property ($fell(write_enable_n) |-> !chip_select_n)
    else $error("write strobe fell without chip select");
  a_read_no_write: assert property (!output_enable_n |-> write_enable_n)
    else $error("write strobe low during read");
  a_lane_no_clash: assert property (byte_lane_oe |-> output_enable_n)
    else $error("host drives lane while memory outputs enabled");
  a_write_length: assert property ($fell(write_enable_n) |-> (!write_enable_n) [*2])
    else $error("write strobe shorter than float plus setup");
  a_data_hold: assert property ($rose(write_enable_n) |-> byte_lane_oe && $stable(byte_lane_out))
    else $error("write data not held at write end");
  a_write_addr: assert property ((!chip_select_n && !write_enable_n) |=> write_enable_n || $stable(word_address))
    else $error("address moved inside write");
  a_read_addr: assert property ((!chip_select_n && write_enable_n) |=> chip_select_n || $stable(word_address))
    else $error("address moved inside read");
  a_read_answer: assert property ((req_valid && req_ready && !req_write) |-> ##[5:6] rsp_valid)
    else $error("read answer late");
endmodule : sram_host_props
`default_nettype wire

//--- tb/sram_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_errors++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module sram_host_tb
  import sram_host_pkg::*;
;
  localparam int PU = 8;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_wdata = '0;
  logic req_ready, rsp_valid, chip_select_n, output_enable_n, write_enable_n, byte_lane_oe, mem_en, standby;
  logic [DATA_W-1:0] rsp_rdata, byte_lane_out, mem_data;
  logic [ADDR_W-1:0] word_address;
  logic slow = 1'b0;
  logic [DATA_W-1:0] float_pat = 8'h5a;
  wire logic [DATA_W-1:0] byte_lane_in;
  int n_errors = 0;
  int checked = 0;
  // A floating lane carries a moving pattern so stale data never looks right.
  assign byte_lane_in = byte_lane_oe ? byte_lane_out : (mem_en ? mem_data : float_pat);
  always @(posedge mclk) float_pat <= {float_pat[6:0], ~float_pat[7]};
  initial forever #5 mclk = ~mclk;
  sram_host #(.POWERUP_CYCLES(PU)) u_sram_host (.mclk(mclk), .reset(reset), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .word_address(word_address), .chip_select_n(chip_select_n),
    .output_enable_n(output_enable_n), .write_enable_n(write_enable_n), .byte_lane_in(byte_lane_in),
    .byte_lane_out(byte_lane_out), .byte_lane_oe(byte_lane_oe));
  sram_model u_sram_model (.chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
    .write_enable_n(write_enable_n), .word_address(word_address), .lane(byte_lane_in), .slow(slow),
    .drive_en(mem_en), .drive_data(mem_data), .standby(standby));
  // ------------------------------------------------
  // Bus tasks and scenarios
  // ------------------------------------------------
  task automatic req(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 50)
    begin
      @(negedge mclk);
      n++;
    end
    `CHK("ready", 1'b1, req_ready)
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    @(negedge mclk);
    req_valid = 1'b0;
  endtask : req
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ex);
    int n;
    req(1'b0, a, 8'h00);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20)
    begin
      @(negedge mclk);
      n++;
    end
    `CHK("rsp_valid", 1'b1, rsp_valid)
    `CHK("rdata", ex, rsp_rdata)
  endtask : rd
  // Reset state of the pins, then a quiet power-up wait.
  task automatic t_powerup();
    repeat (12) @(negedge mclk);
    `CHK("cs_rst", 1'b1, chip_select_n)
    `CHK("oe_rst", 1'b0, byte_lane_oe)
    reset = 1'b0;
    repeat (PU - 1)
    begin
      @(negedge mclk);
      `CHK("cs_wait", 1'b1, chip_select_n)
      `CHK("rdy_wait", 1'b0, req_ready)
    end
    $display("test powerup done");
  endtask : t_powerup
  // Lowest, highest and a middle address, written back to back then read.
  task automatic t_data();
    logic [ADDR_W-1:0] ad [3] = '{20'h00000, 20'hfffff, 20'h5a5a5};
    for (int i = 0; i < 3; i++)
      req(1'b1, ad[i], 8'h11 * DATA_W'(i + 1));
    // One cycle on, both strobes are low and the write is in progress.
    @(negedge mclk);
    `CHK("mem_float", 1'b0, mem_en)
    for (int i = 0; i < 3; i++)
      rd(ad[i], 8'h11 * DATA_W'(i + 1));
    $display("test data done");
  endtask : t_data
  // Overwrite then read at once, with prompt and slow memory.
  task automatic t_back();
    req(1'b1, 20'h00100, 8'ha5);
    req(1'b1, 20'h00100, 8'h3c);
    rd(20'h00100, 8'h3c);
    slow = 1'b1;
    rd(20'h00100, 8'h3c);
    slow = 1'b0;
    // Select rose one and a half cycles ago; standby is due within the deselect time.
    @(negedge mclk);
    `CHK("standby", 1'b1, standby)
    $display("test back done");
  endtask : t_back
  // Reset in the middle of a write, then recovery after the wait.
  task automatic t_reset();
    req(1'b1, 20'h00033, 8'h77);
    @(negedge mclk);
    reset = 1'b1;
    @(negedge mclk);
    `CHK("cs_abort", 1'b1, chip_select_n)
    `CHK("we_abort", 1'b1, write_enable_n)
    reset = 1'b0;
    rd(20'h00044, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  initial
  begin
    t_powerup();
    t_data();
    t_back();
    t_reset();
    wrap_up();
  end
  // The run needs well under a thousand cycles; this cuts a hang short.
  initial
  begin
    #100000;
    n_errors++;
    wrap_up();
  end
endmodule : sram_host_tb
bind sram_host sram_host_props #(.POWERUP_CYCLES(POWERUP_CYCLES)) u_sram_host_props (.mclk(mclk), .reset(reset),
  .req_valid(req_valid), .req_write(req_write), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .word_address(word_address), .chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
  .write_enable_n(write_enable_n), .byte_lane_out(byte_lane_out), .byte_lane_oe(byte_lane_oe));
`default_nettype wire

//--- tb/sram_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// Behavioural byte-wide static memory
// ------------------------------------------------
module sram_model
  import sram_host_pkg::*;
(
  // Strobes and address
  input wire logic chip_select_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic [ADDR_W-1:0] word_address,
  // Resolved lane and this side's drive
  input wire logic [DATA_W-1:0] lane,
  input wire logic slow,
  output logic drive_en,
  output logic [DATA_W-1:0] drive_data,
  output logic standby
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic in_write = 1'b0;
  logic rd_ok = 1'b0;
  // The overlap of both strobes is the write; the first strobe to rise stores the byte.
  always @(chip_select_n or write_enable_n)
  begin
    if (!chip_select_n && !write_enable_n)
      in_write = 1'b1;
    else if (in_write)
    begin
      mem[word_address] = lane;
      in_write = 1'b0;
    end
  end
  // Data appears one access time late; a slow part adds half a clock to show the capture margin.
  always @(chip_select_n or output_enable_n or write_enable_n or word_address)
  begin
    rd_ok = 1'b0;
    if (!chip_select_n && !output_enable_n && write_enable_n)
      rd_ok <= #(slow ? ACCESS_TIME_NS + CLK_PERIOD_NS / 2 : ACCESS_TIME_NS) 1'b1;
  end
  // Unwritten places read as zero.
  always @(word_address or in_write)
    drive_data = mem.exists(word_address) ? mem[word_address] : 8'h00;
  // Floats when deselected, outputs off or writing.
  assign drive_en = rd_ok && !chip_select_n && !output_enable_n && write_enable_n;
  assign #(DESELECT_TO_STANDBY_TIME_NS) standby = chip_select_n;
endmodule : sram_model
`default_nettype wire
